/* File: design/dci_consts.svh */
// constants for the command and address input decode block
// assumes it is included by bare name by the package and the decoder
`ifndef DCI_CONSTS_SVH
`define DCI_CONSTS_SVH

// field widths of the pin group
`define DCI_BANK_W      3
`define DCI_NUM_BANKS   8
`define DCI_ADDR_W      13
`define DCI_COL_W       10
// field positions inside the address pins during a column command
`define DCI_COL_MSB     9
`define DCI_AP_BIT      10

// timing: precharge time in ns and system clock rate in MHz
`define DCI_TRP_NS      15
`define DCI_CLK_MHZ     25
// least time, so round up; never under one cycle
`define DCI_PRE_RAW     ((`DCI_TRP_NS * `DCI_CLK_MHZ + 999) / 1000)
`define DCI_PRE_CYCLES  ((`DCI_PRE_RAW < 1) ? 1 : `DCI_PRE_RAW)

// reset values
`define DCI_BANKS_IDLE  8'h00

`endif

/* File: design/dci_decode.sv */
// command and address input decode of an eight-bank ddr2 sdram
// assumes host pins are asynchronous to clk and the host clock is far slower than clk
`timescale 1ns/1ps
`default_nettype none
`include "dci_consts.svh"

// What this block does
// - sample all inputs only where true clock rises and complement falls
// - read data beats are timed from crossings in both directions
// - clock enable sampled low suspends internal clock; outputs freeze until high
// - low clock enable enters power-down only when every bank is idle
// - bank select picks the bank for activate, read, write, precharge
// - activate captures all thirteen address bits as the row address
// - read and write take column from low ten bits, bit ten auto precharge
// - chip select high masks every command
// - cs low, ras low, cas high, we high decodes activate, bank active
// - cs low, ras low, cas high, we low decodes precharge, bank idle after
// - cs low, ras high, cas low starts read with we high, write low
module dci_decode
(
  input  wire logic                    clk,
  input  wire logic                    rst_b,
  input  wire logic                    clock_true,
  input  wire logic                    clock_complement,
  input  wire logic                    cke,
  input  wire logic                    cs_b,
  input  wire logic                    ras_b,
  input  wire logic                    cas_b,
  input  wire logic                    we_b,
  input  wire logic [`DCI_BANK_W-1:0]  bank_select,
  input  wire logic [`DCI_ADDR_W-1:0]  mux_address,
  output logic                         bank_activate_a,
  output logic                         precharge_cmd,
  output logic                         read_cmd,
  output logic                         write_cmd,
  output logic [`DCI_BANK_W-1:0]       cmd_bank,
  output logic [`DCI_ADDR_W-1:0]       row_address,
  output logic [`DCI_COL_W-1:0]        column_address,
  output logic                         auto_precharge_flag,
  output logic [`DCI_NUM_BANKS-1:0]    bank_active,
  output logic                         clock_suspended,
  output logic                         power_down,
  output logic                         read_beat
);

  import dci_pkg::*;

  localparam int PRE_CYCLES = `DCI_PRE_CYCLES;
  localparam int PRE_MAX    = `DCI_PRE_CYCLES + 1;

  typedef struct packed {
    dci_pins_s                  pin1;      // first synchroniser stage
    dci_pins_s                  pin2;      // second synchroniser stage
    logic                       true_prev;
    logic                       comp_prev;
    dci_mode_e                  mode;
    logic [`DCI_NUM_BANKS-1:0]  active;
    logic [`DCI_NUM_BANKS-1:0]  pend;      // banks waiting for precharge to finish
    logic [7:0]                 pend_cnt;
    logic                       act_p;
    logic                       pre_p;
    logic                       rd_p;
    logic                       wr_p;
    logic [`DCI_BANK_W-1:0]     bank;
    logic [`DCI_ADDR_W-1:0]     row;
    logic [`DCI_COL_W-1:0]      col;
    logic                       ap;
    logic                       beat;
  } dci_state_s;

  dci_state_s st;
  dci_state_s next_st;
  dci_pins_s  pins_in;
  logic       rise_x;
  logic       fall_x;

  // decode the command code; chip select is part of it
  function automatic logic [3:0] cmd_of(input dci_pins_s p);
    cmd_of = {p.cs_b, p.ras_b, p.cas_b, p.we_b};
  endfunction

  // true when no bank is open and none is still precharging
  function automatic logic all_idle(input dci_state_s s);
    all_idle = (s.active == `DCI_BANKS_IDLE) && (s.pend == `DCI_BANKS_IDLE);
  endfunction

  // gather the pins into one sample word
  assign pins_in = '{clock_true, clock_complement, cke, cs_b, ras_b, cas_b, we_b,
                     bank_select, mux_address};

  // crossings, seen only on synchronised samples so the first stage stays private
  assign rise_x = st.pin2.clock_true & ~st.true_prev
                & ~st.pin2.clock_complement & st.comp_prev;
  assign fall_x = ~st.pin2.clock_true & st.true_prev
                & st.pin2.clock_complement & ~st.comp_prev;

  // next-state logic
  always_comb
  begin
    next_st          = st;
    next_st.pin1     = pins_in;
    next_st.pin2     = st.pin1;
    next_st.true_prev = st.pin2.clock_true;
    next_st.comp_prev = st.pin2.clock_complement;
    next_st.act_p    = 1'b0;
    next_st.pre_p    = 1'b0;
    next_st.rd_p     = 1'b0;
    next_st.wr_p     = 1'b0;
    // one beat per crossing in either direction, frozen while suspended
    next_st.beat     = (rise_x | fall_x) & (st.mode == DCI_RUN);

    // precharge countdown only runs while the internal clock runs
    if (st.mode == DCI_RUN && st.pend_cnt != 8'h00)
    begin
      next_st.pend_cnt = st.pend_cnt - 8'h01;
      if (st.pend_cnt == 8'h01)
      begin
        next_st.active = st.active & ~st.pend;
        next_st.pend   = `DCI_BANKS_IDLE;
      end
    end

    if (rise_x)
    begin
      unique case (st.mode)
        DCI_RUN:
        begin
          // commands decode only while running; cs high skips the case and decodes nothing
          if (!st.pin2.cs_b)
          begin
            unique case (cmd_of(st.pin2))
              DCI_CMD_ACT:
              begin
                next_st.act_p = 1'b1;
                next_st.bank  = st.pin2.bank_select;
                next_st.row   = st.pin2.mux_address;
                next_st.active[st.pin2.bank_select] = 1'b1;
                next_st.pend[st.pin2.bank_select]   = 1'b0;
              end
              DCI_CMD_PRE:
              begin
                next_st.pre_p = 1'b1;
                next_st.bank  = st.pin2.bank_select;
                next_st.pend[st.pin2.bank_select] = 1'b1;
                next_st.pend_cnt = 8'(PRE_CYCLES);
              end
              DCI_CMD_RD, DCI_CMD_WR:
              begin
                next_st.rd_p = st.pin2.we_b;
                next_st.wr_p = ~st.pin2.we_b;
                next_st.bank = st.pin2.bank_select;
                next_st.col  = st.pin2.mux_address[`DCI_COL_MSB:0];
                next_st.ap   = st.pin2.mux_address[`DCI_AP_BIT];
                // burst length is not modelled, so auto precharge starts at once
                if (st.pin2.mux_address[`DCI_AP_BIT])
                begin
                  next_st.pend[st.pin2.bank_select] = 1'b1;
                  next_st.pend_cnt = 8'(PRE_CYCLES);
                end
              end
              default:
              begin
                next_st.act_p = 1'b0; // other codes are out of scope here
              end
            endcase
          end
          // low clock enable stops the internal clock from the next cycle
          // judged on the banks after this crossing's own command, so an activate
          // on the same crossing forces suspend rather than power-down
          if (!st.pin2.cke)
          begin
            if (all_idle(next_st))
              next_st.mode = DCI_PDOWN;
            else
              next_st.mode = DCI_SUSP;
          end
        end
        DCI_SUSP, DCI_PDOWN:
        begin
          if (st.pin2.cke)
            next_st.mode = DCI_RUN;
        end
        default:
        begin
          next_st.mode = DCI_RUN; // illegal code recovers to run
        end
      endcase
    end
  end

  // state register, synchronous active-low reset
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      st        <= '0;
      st.mode   <= DCI_RUN;
      st.active <= `DCI_BANKS_IDLE;
      st.pend   <= `DCI_BANKS_IDLE;
    end
    else
    begin
      st <= next_st;
    end
  end

  // outputs come straight from the state register
  assign bank_activate_a     = st.act_p;
  assign precharge_cmd       = st.pre_p;
  assign read_cmd            = st.rd_p;
  assign write_cmd           = st.wr_p;
  assign cmd_bank            = st.bank;
  assign row_address         = st.row;
  assign column_address      = st.col;
  assign auto_precharge_flag = st.ap;
  assign bank_active         = st.active;
  assign clock_suspended     = st.mode[0]; // gray code: suspend and power-down share bit 0
  assign power_down          = st.mode[1]; // only power-down sets bit 1
  assign read_beat           = st.beat;

  // checks on the decoder
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence s_cmd;
    bank_activate_a || precharge_cmd || read_cmd || write_cmd;
  endsequence

  sequence s_rise_run;
    rise_x && st.mode == DCI_RUN && !st.pin2.cs_b;
  endsequence

  property p_only_rise;
    s_cmd |-> $past(rise_x);
  endproperty
  a_only_rise: assert property (p_only_rise)
    else $error("command decoded without a rising crossing");

  property p_beat;
    (fall_x || rise_x) && st.mode == DCI_RUN |=> read_beat;
  endproperty
  a_beat: assert property (p_beat)
    else $error("read beat missing after a crossing");

  property p_freeze;
    st.mode != DCI_RUN && !rise_x |=> $stable(row_address) && $stable(column_address)
      && !bank_activate_a && !read_beat;
  endproperty
  a_freeze: assert property (p_freeze)
    else $error("outputs moved while clock suspended");

  property p_pdown_idle;
    power_down |-> bank_active == `DCI_BANKS_IDLE;
  endproperty
  a_pdown_idle: assert property (p_pdown_idle)
    else $error("power-down entered with an open bank");

  property p_bank;
    s_cmd |-> cmd_bank == $past(st.pin2.bank_select);
  endproperty
  a_bank: assert property (p_bank)
    else $error("command bank does not match bank select");

  property p_row;
    bank_activate_a |-> row_address == $past(st.pin2.mux_address);
  endproperty
  a_row: assert property (p_row)
    else $error("row address not captured on activate");

  property p_col;
    read_cmd || write_cmd |-> column_address == $past(st.pin2.mux_address[`DCI_COL_MSB:0])
      && auto_precharge_flag == $past(st.pin2.mux_address[`DCI_AP_BIT]);
  endproperty
  a_col: assert property (p_col)
    else $error("column address or auto precharge wrong");

  property p_cs_mask;
    rise_x && st.pin2.cs_b |=> !bank_activate_a && !precharge_cmd && !read_cmd && !write_cmd;
  endproperty
  a_cs_mask: assert property (p_cs_mask)
    else $error("command decoded with chip select high");

  property p_act;
    s_rise_run ##0 (cmd_of(st.pin2) == DCI_CMD_ACT) |=> bank_activate_a && bank_active[cmd_bank];
  endproperty
  a_act: assert property (p_act)
    else $error("activate did not open the bank");

  property p_pre;
    // the countdown freezes while suspended, so only a running precharge is timed
    precharge_cmd && !clock_suspended |-> ##[1:PRE_MAX] !bank_active[cmd_bank] || bank_activate_a;
  endproperty
  a_pre: assert property (p_pre)
    else $error("precharged bank did not go idle");

  property p_rw;
    s_rise_run ##0 (!st.pin2.ras_b || st.pin2.cas_b) |=> !read_cmd && !write_cmd;
  endproperty
  a_rw: assert property (p_rw)
    else $error("column access decoded on a wrong code");

  property p_rd_we;
    read_cmd |-> $past(st.pin2.we_b) && !write_cmd;
  endproperty
  a_rd_we: assert property (p_rd_we)
    else $error("read decoded with write select low");

endmodule : dci_decode
`default_nettype wire

/* File: design/dci_pkg.sv */
// types shared by the command and address input decode block
// assumes dci_consts.svh is on the include path
`include "dci_consts.svh"

package dci_pkg;

  // command code as {chip select, row strobe, column strobe, write select}
  typedef enum logic [3:0] {
    DCI_CMD_ACT = 4'h3,
    DCI_CMD_PRE = 4'h2,
    DCI_CMD_RD  = 4'h5,
    DCI_CMD_WR  = 4'h4
  } dci_cmd_e;

  // clock-enable mode, gray coded along run -> suspend -> power-down
  typedef enum logic [1:0] {
    DCI_RUN   = 2'h0,
    DCI_SUSP  = 2'h1,
    DCI_PDOWN = 2'h3
  } dci_mode_e;

  // one sample of the host-driven pins
  typedef struct packed {
    logic                    clock_true;
    logic                    clock_complement;
    logic                    cke;
    logic                    cs_b;
    logic                    ras_b;
    logic                    cas_b;
    logic                    we_b;
    logic [`DCI_BANK_W-1:0]  bank_select;
    logic [`DCI_ADDR_W-1:0]  mux_address;
  } dci_pins_s;

endpackage : dci_pkg

/* File: test/dci_decode_bench.sv */
// self-checking bench of the command and address input decode block
// assumes dci_host.sv as the pin driver and a 25 MHz system clock
`timescale 1ns/1ps
`default_nettype none
`include "dci_consts.svh"
module ddr2_command_input_decode_bench;
  import dci_pkg::*;
  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        clock_true, clock_complement, cke, cs_b, ras_b, cas_b, we_b;
  logic [2:0]  bank_select, cmd_bank;
  logic [12:0] mux_address, row_address;
  logic [9:0]  column_address;
  logic [7:0]  bank_active, e_act;
  logic        bank_activate_a, precharge_cmd, read_cmd, write_cmd;
  logic        auto_precharge_flag, clock_suspended, power_down, read_beat;
  logic [3:0]  n_act = 4'h0, n_pre = 4'h0, n_rd = 4'h0, n_wr = 4'h0, n_beat = 4'h0;
  int          failures = 0;
  int          cmp_count = 0;

  dci_host dci_host_inst (.clk, .clock_true, .clock_complement, .cke, .cs_b, .ras_b,
    .cas_b, .we_b, .bank_select, .mux_address);
  dci_decode dci_decode_inst (.clk, .rst_b, .clock_true, .clock_complement, .cke,
    .cs_b, .ras_b, .cas_b, .we_b, .bank_select, .mux_address, .bank_activate_a,
    .precharge_cmd, .read_cmd, .write_cmd, .cmd_bank, .row_address, .column_address,
    .auto_precharge_flag, .bank_active, .clock_suspended, .power_down, .read_beat);

  always #20 clk = ~clk;

  // count pulses; a double pulse shows up as a count of two
  always @(posedge clk)
  begin
    n_act += {3'h0, bank_activate_a === 1'b1};
    n_pre += {3'h0, precharge_cmd === 1'b1};
    n_rd += {3'h0, read_cmd === 1'b1};
    n_wr += {3'h0, write_cmd === 1'b1};
    n_beat += {3'h0, read_beat === 1'b1};
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one host period, then pulse counts, beats and open banks judged
  task automatic op(input logic [3:0] code, input logic [2:0] bank, input logic [12:0] addr,
                    input logic en, input logic [15:0] e_cnt, input logic [3:0] e_beat);
    logic [19:0] base;
    // counters belong to the counting process; judge the difference, modulo 16
    base = {n_act, n_pre, n_rd, n_wr, n_beat};
    dci_host_inst.send(code, bank, addr, en);
    chk({n_act - base[19:16], n_pre - base[15:12], n_rd - base[11:8], n_wr - base[7:4]}, e_cnt);
    chk({12'h000, n_beat - base[3:0]}, {12'h000, e_beat});
    chk({8'h00, bank_active}, {8'h00, e_act});
  endtask

  task automatic t_activate();
    chk({13'h0000, clock_suspended, power_down, read_beat}, 16'h0000);
    for (int b = 0; b < `DCI_NUM_BANKS; b++)
    begin
      e_act[b] = 1'b1;
      op(4'h3, 3'(b), 13'h1555 ^ 13'(b), 1'b1, 16'h1000, 4'h2);
      chk({13'h0000, cmd_bank}, 16'(b));
      chk({3'h0, row_address}, 16'h1555 ^ 16'(b));
    end
    $display("test activate done");
  endtask

  task automatic t_column();
    op(4'h5, 3'h3, 13'h02AA, 1'b1, 16'h0010, 4'h2);
    chk({5'h00, auto_precharge_flag, column_address}, 16'h02AA);
    op(4'h4, 3'h5, 13'h1855, 1'b1, 16'h0001, 4'h2);
    chk({2'h0, auto_precharge_flag, column_address, cmd_bank}, 16'h02AD);
    e_act[3] = 1'b0;
    op(4'h5, 3'h3, 13'h07FF, 1'b1, 16'h0010, 4'h2);
    chk({5'h00, auto_precharge_flag, column_address}, 16'h07FF);
    $display("test column done");
  endtask

  // chip select high, plus a no-operation code, must decode nothing
  task automatic t_deselect();
    logic [3:0] codes [5] = '{4'hB, 4'hA, 4'hD, 4'hC, 4'h7};
    foreach (codes[i])
      op(codes[i], 3'h3, 13'h0ABC, 1'b1, 16'h0000, 4'h2);
    chk({3'h0, row_address}, 16'h1552);
    e_act[0] = 1'b0;
    op(4'h2, 3'h0, 13'h0000, 1'b1, 16'h0100, 4'h2);
    $display("test deselect and precharge done");
  endtask

  // clock enable low with banks open suspends only; then idle banks allow power-down
  task automatic t_lowpower();
    dci_host_inst.send(4'h7, 3'h0, 13'h0000, 1'b0);
    chk({14'h0000, clock_suspended, power_down}, 16'h0002);
    op(4'h3, 3'h0, 13'h0123, 1'b0, 16'h0000, 4'h0);
    chk({3'h0, row_address}, 16'h1552);
    dci_host_inst.send(4'h7, 3'h0, 13'h0000, 1'b1);
    chk({14'h0000, clock_suspended, power_down}, 16'h0000);
    for (int b = 1; b < `DCI_NUM_BANKS; b++)
    begin
      e_act[b] = 1'b0;
      op(4'h2, 3'(b), 13'h0000, 1'b1, 16'h0100, 4'h2);
    end
    dci_host_inst.send(4'h7, 3'h0, 13'h0000, 1'b0);
    chk({14'h0000, clock_suspended, power_down}, 16'h0003);
    dci_host_inst.send(4'h7, 3'h0, 13'h0000, 1'b1);
    chk({14'h0000, clock_suspended, power_down}, 16'h0000);
    $display("test low power done");
  endtask

  // about 30 host periods of 15 cycles each; 200 us leaves a wide margin
  initial
  begin
    #200000;
    failures++;
    give_verdict();
  end

  // reset 16 cycles, let the synchronisers flush, then run the scenarios
  initial
  begin
    e_act = 8'h00;
    repeat (16) @(posedge clk);
    #1 rst_b = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    t_activate();
    t_column();
    t_deselect();
    t_lowpower();
    give_verdict();
  end
endmodule // ddr2_command_input_decode_bench
`default_nettype wire

/* File: test/dci_host.sv */
// host controller model: clock pair, clock enable, command and address pins
// assumes clk is the device system clock; host clock stops between frames
`timescale 1ns/1ps
`default_nettype none
`include "dci_consts.svh"
module dci_host
(
  input  wire logic                  clk,
  output logic                       clock_true,
  output logic                       clock_complement,
  output logic                       cke,
  output logic                       cs_b,
  output logic                       ras_b,
  output logic                       cas_b,
  output logic                       we_b,
  output logic [`DCI_BANK_W-1:0]     bank_select,
  output logic [`DCI_ADDR_W-1:0]     mux_address
);
  // parked: clock pair low/high, clock enabled, deselected
  initial
  begin
    {clock_true, clock_complement, cke} = 3'h3;
    {cs_b, ras_b, cas_b, we_b} = 4'hF;
    bank_select = 3'h0;
    mux_address = 13'h0000;
  end

  // one host clock period, half period of 5 clk cycles to clear the 3-cycle floor
  task automatic send(input logic [3:0] code, input logic [2:0] bank,
                      input logic [12:0] addr, input logic en);
    {cs_b, ras_b, cas_b, we_b} = code;
    bank_select = bank;
    mux_address = addr;
    cke = en;
    repeat (5) @(posedge clk);
    #1 {clock_true, clock_complement} = 2'h2;
    repeat (5) @(posedge clk);
    #1 {clock_true, clock_complement} = 2'h1;
    repeat (4) @(posedge clk);
    // hold time over: show the inverse so a stale value never passes
    #1 bank_select = ~bank;
    mux_address = ~addr;
    {cs_b, ras_b, cas_b, we_b} = 4'hF;
    @(posedge clk);
    #1;
  endtask
endmodule // dci_host
`default_nettype wire
